// [bench/pcb_burst_ctl_props.sv]
// port assertions for the cache line burst controller
`timescale 1ns/1ps
module pcb_burst_ctl_props #(
  parameter int FIFO_LVL_W = 10
) (
  // clock, reset, config access
  input wire logic                  clock,
  input wire logic                  reset,
  input wire logic                  cfg_wr,
  input wire logic                  cfg_rd,
  input wire logic [7:0]            cfg_addr,
  input wire logic [7:0]            cfg_wdata,
  input wire logic [7:0]            cfg_rdata,
  // enables and limits
  input wire logic                  pci_cmd_mwi_en,
  input wire logic                  line_size_enable,
  input wire logic                  write_invalidate_enable,
  input wire logic [1:0]            dma_mode_burst,
  input wire logic                  burst_ext,
  input wire logic                  xfer_mem_move,
  input wire logic [FIFO_LVL_W-1:0] fifo_bytes,
  // bursts
  input wire logic                  burst_req,
  input wire logic [31:0]           burst_addr,
  input wire logic [9:0]            burst_bytes,
  input wire logic [3:0]            burst_cmd,
  input wire logic                  burst_ack,
  input wire logic                  data_ack,
  input wire logic                  target_stop
);
  logic [7:0] cls_q;
  logic [9:0] line_b;
  logic       mwi;
  // shadow of the line size register so command choice can be judged
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cls_q <= 8'h00;
    end else if (cfg_wr && cfg_addr == 8'h0C) begin
      cls_q <= cfg_wdata;
    end
  end
  // line in bytes; only meaningful once the line size is legal
  assign line_b = {cls_q, 2'b00};
  assign mwi    = burst_req && burst_cmd == 4'hF;
  default clocking dcb @(posedge clock);
  endclocking
  default disable iff (reset);
  a_cls_read_back: assert property (cfg_rd && cfg_addr == 8'h0C |=> cfg_rdata == $past(cls_q))
    else $error("line size read back wrong");
  a_mwi_enables: assert property (mwi |-> pci_cmd_mwi_en && line_size_enable && write_invalidate_enable)
    else $error("invalidate with an enable off");
  a_mwi_legal_line: assert property (mwi |-> $onehot(cls_q) && cls_q >= 8'h02)
    else $error("invalidate with illegal line size");
  a_mwi_fifo_line: assert property (mwi |-> fifo_bytes >= line_b)
    else $error("invalidate without a full line queued");
  a_mwi_line_aligned: assert property (mwi |-> (burst_addr[9:0] & (line_b - 10'h001)) == 10'h000)
    else $error("invalidate off a line boundary");
  a_mwi_whole_lines: assert property (mwi |-> (burst_bytes & (line_b - 10'h001)) == 10'h000)
    else $error("invalidate burst not whole lines");
  a_unaligned_single: assert property (burst_req && line_size_enable && cls_q >= 8'h04 && !xfer_mem_move
    && (burst_ext || dma_mode_burst != 2'h0) && burst_addr[3:0] != 4'h0 |-> burst_bytes <= 10'h004)
    else $error("burst before four-dword alignment");
  a_retry_reissue: assert property (mwi && burst_ack ##1 target_stop && !data_ack
    |-> ##2 mwi && burst_addr == $past(burst_addr, 3))
    else $error("retry not reissued as invalidate");
  c_mwi_burst: cover property (mwi && burst_ack);
  c_retry: cover property (target_stop && !data_ack);
  c_odd_start: cover property (burst_req && burst_ack && burst_addr[1:0] != 2'h0);
endmodule

bind pcb_burst_ctl pcb_burst_ctl_props #(.FIFO_LVL_W(FIFO_LVL_W)) u_props (.*);

// [bench/pcb_bus_model.sv]
// far-side bus engine and target: takes bursts, answers data phases
`timescale 1ns/1ps
module pcb_bus_model (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        reset,
  // burst from the controller
  input  wire logic        burst_req,
  input  wire logic [31:0] burst_addr,
  input  wire logic [9:0]  burst_bytes,
  input  wire logic        bus_release,
  // controls: stop kind 1 retry, 2 disconnect; ack delay
  input  wire logic [1:0]  stop_mode,
  input  wire logic [3:0]  ack_wait,
  // answers
  output logic             burst_ack,
  output logic             data_ack,
  output logic             target_stop
);
  int   left;
  int   waited;
  logic stop_q;
  logic used;
  // a stop is given once per setting, or a retry would repeat forever
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      {burst_ack, data_ack, target_stop, stop_q, used} <= '0;
      waited = 0;
    end else begin
      burst_ack <= 1'b0;
      target_stop <= 1'b0;
      // a zero setting re-arms the one-shot stop for the next setting
      if (stop_mode == 2'h0) begin
        used <= 1'b0;
      end
      if (burst_req && burst_ack) begin
        left = int'(burst_bytes) + int'(burst_addr[1:0]); // first phase ends at the dword edge
        waited = 0;
        used <= stop_mode != 2'h0;
        stop_q <= stop_mode == 2'h2 && !used;
        target_stop <= stop_mode == 2'h1 && !used;
        data_ack <= !(stop_mode == 2'h1 && !used);
      end else if (data_ack) begin
        left = left - 4;
        data_ack <= !(stop_q || left <= 0 || bus_release);
        target_stop <= stop_q;
        stop_q <= 1'b0;
      end else if (burst_req) begin
        waited = waited + 1;
        burst_ack <= waited > int'(ack_wait);
      end
    end
  end
endmodule

// [bench/test_pcb_burst_ctl.sv]
// self-checking bench for the cache line burst controller
`timescale 1ns/1ps
module test_pcb_burst_ctl;
  import pcb_pkg::*;
  logic        clock = 1'b0, reset = 1'b1, cfg_wr = 1'b0, cfg_rd = 1'b0, burst_ext = 1'b0;
  logic        xfer_start = 1'b0, xfer_write = 1'b0, xfer_mem_move = 1'b0, latency_expired = 1'b0;
  logic        pci_cmd_mwi_en = 1'b1, line_size_enable = 1'b1, write_invalidate_enable = 1'b1;
  logic        read_line_enable = 1'b0, read_multiple_enable = 1'b0;
  logic        burst_req, burst_ack, data_ack, target_stop, bus_release, xfer_busy, xfer_done;
  logic [7:0]  cfg_addr = 8'h00, cfg_wdata = 8'h00, cfg_rdata;
  logic [1:0]  dma_mode_burst = 2'h3, stop_mode = 2'h0;
  logic [3:0]  ack_wait = 4'h0, burst_cmd;
  logic [9:0]  fifo_bytes = 10'h3E8, burst_bytes;
  logic [23:0] xfer_count = 24'h0;
  logic [31:0] xfer_addr = 32'h0, xfer_peer_addr = 32'h0, burst_addr;
  logic [45:0] seen[$], want[$];
  int          errors = 0, total_checks = 0, rel_n = 0;

  pcb_burst_ctl #(.FIFO_LVL_W(10)) u_dut (.*);
  pcb_bus_model u_far (.*);

  initial begin
    forever #10 clock = ~clock;
  end
  // log each burst at the edge the far side takes it
  always @(posedge clock) begin
    if (burst_req && burst_ack) begin
      seen.push_back({burst_addr, burst_bytes, burst_cmd});
    end
    if (bus_release && data_ack) begin
      rel_n++;
    end
  end

  task automatic check(input logic [45:0] got, input logic [45:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic exp_b(input logic [31:0] a, input logic [9:0] b, input logic [3:0] c);
    want.push_back({a, b, c});
  endtask

  // one config access; read data is looked at after the second edge
  task automatic reg_io(input logic wr, input logic [7:0] a, input logic [7:0] d);
    cfg_wr <= wr;
    cfg_rd <= !wr;
    cfg_addr <= a;
    cfg_wdata <= d;
    @(posedge clock);
    cfg_wr <= 1'b0;
    cfg_rd <= 1'b0;
    @(posedge clock);
  endtask

  // run one transfer, then compare the logged bursts with the expected head
  task automatic xfer(input logic w, input logic m, input logic [31:0] a, input logic [31:0] p,
                      input logic [23:0] c);
    int n;
    seen.delete();
    xfer_write <= w;
    xfer_mem_move <= m;
    xfer_addr <= a;
    xfer_peer_addr <= p;
    xfer_count <= c;
    xfer_start <= 1'b1;
    @(posedge clock);
    xfer_start <= 1'b0;
    @(posedge clock);
    check(46'(xfer_busy), 46'h1);
    for (n = 0; n < 1000 && xfer_done !== 1'b1; n++) begin
      @(posedge clock);
    end
    check(46'(n < 1000), 46'h1);
    check(46'(xfer_busy), 46'h0);
    foreach (want[i]) begin
      check(i < seen.size() ? seen[i] : 46'bx, want[i]);
    end
    want.delete();
  endtask

  task automatic print_verdict();
    $display("mismatches %0d, checks %0d", errors, total_checks);
    if (errors == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // reset value, write and read back, unmapped offset reads zero
  task automatic t_cfg();
    reg_io(1'b0, 8'h0C, 8'h00);
    check(46'(cfg_rdata), 46'(PCB_CLS_RESET));
    reg_io(1'b1, 8'h0C, 8'h13);
    reg_io(1'b0, 8'h0C, 8'h00);
    check(46'(cfg_rdata), 46'h13);
    reg_io(1'b1, 8'h20, 8'h55);
    reg_io(1'b0, 8'h20, 8'h00);
    check(46'(cfg_rdata), 46'h0);
  endtask

  // line 13h rounds to 16 dwords: singles, then 4, 8, then whole lines
  task automatic t_align();
    exp_b(32'h01, 10'h003, PCB_CMD_MEM_READ);
    for (int i = 1; i < 4; i++) begin
      exp_b(32'(4 * i), 10'h004, PCB_CMD_MEM_READ);
    end
    exp_b(32'h10, 10'h010, PCB_CMD_MEM_READ);
    exp_b(32'h20, 10'h020, PCB_CMD_MEM_READ);
    exp_b(32'h40, 10'h040, PCB_CMD_MEM_READ);
    xfer(1'b0, 1'b0, 32'h01, 32'h0, 24'h7F);
  endtask

  // memory move, sides at unequal line offsets: legacy sizing, no stepping
  task automatic t_move();
    exp_b(32'h01, 10'h003, PCB_CMD_MEM_READ);
    exp_b(32'h04, 10'h040, PCB_CMD_MEM_READ);
    xfer(1'b0, 1'b1, 32'h01, 32'h11, 24'h43);
  endtask

  // four-dword line, 16-dword limit, slow acks: bursts shrink near the end
  task automatic t_multi();
    reg_io(1'b1, 8'h0C, 8'h04);
    ack_wait <= 4'h5;
    exp_b(32'h00, 10'h040, PCB_CMD_WR_INVAL);
    exp_b(32'h40, 10'h030, PCB_CMD_WR_INVAL);
    xfer(1'b1, 1'b0, 32'h0, 32'h0, 24'h70);
    ack_wait <= 4'h0;
  endtask

  // each missing condition in turn falls back to plain write; last pass restores the enables but writes the illegal line size 14h
  task automatic t_gate();
    for (int i = 0; i < 5; i++) begin
      reg_io(1'b1, 8'h0C, i == 4 ? 8'h14 : 8'h10);
      pci_cmd_mwi_en <= i != 0;
      line_size_enable <= i != 1;
      write_invalidate_enable <= i != 2;
      fifo_bytes <= i == 3 ? 10'h03C : 10'h3E8;
      exp_b(32'h40, 10'h040, PCB_CMD_MEM_WRITE);
      xfer(1'b1, 1'b0, 32'h40, 32'h0, 24'h40);
    end
  endtask

  // plain, then retry, then disconnect after one phase
  task automatic t_stop();
    reg_io(1'b1, 8'h0C, 8'h10);
    for (int m = 0; m < 3; m++) begin
      stop_mode <= 2'(m);
      exp_b(32'h40, 10'h040, PCB_CMD_WR_INVAL);
      if (m == 1) begin
        exp_b(32'h40, 10'h040, PCB_CMD_WR_INVAL);
      end else if (m == 2) begin
        exp_b(32'h44, 10'h004, PCB_CMD_MEM_WRITE);
      end
      xfer(1'b1, 1'b0, 32'h40, 32'h0, 24'h40);
      stop_mode <= 2'h0;
      @(posedge clock);
    end
  endtask

  // read multiple wins while two lines remain, read line takes the last
  task automatic t_read();
    read_line_enable <= 1'b1;
    read_multiple_enable <= 1'b1;
    for (int i = 1; i < 5; i++) begin
      exp_b(32'(64 * i), 10'h040, i < 4 ? PCB_CMD_READ_MULT : PCB_CMD_READ_LINE);
    end
    xfer(1'b0, 1'b0, 32'h40, 32'h0, 24'h100);
    read_line_enable <= 1'b0;
    read_multiple_enable <= 1'b0;
  endtask

  // timeout during a multi-line invalidate: each ownership ends at the next line
  task automatic t_latency();
    int r0;
    r0 = rel_n;
    reg_io(1'b1, 8'h0C, 8'h04);
    latency_expired <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      exp_b(32'(16 * i), 10'(64 - 16 * i), PCB_CMD_WR_INVAL);
    end
    xfer(1'b1, 1'b0, 32'h0, 32'h0, 24'h40);
    check(46'(rel_n - r0), 46'h4);
    latency_expired <= 1'b0;
  endtask

  initial begin
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    t_cfg();
    t_align();
    t_move();
    t_multi();
    t_gate();
    t_stop();
    t_read();
    t_latency();
    print_verdict();
  end

  // the run needs under 2000 cycles; 5000 means a hang
  initial begin
    #100000;
    errors++;
    print_verdict();
  end
endmodule

// [rtl/pcb_burst_calc.sv]
// next burst length from address, remaining count and effective line size
`timescale 1ns/1ps

module pcb_burst_calc (
  // current position
  input  wire logic [8:0]  addr_low,
  input  wire logic [23:0] rem_bytes,
  // sizes as dword exponents
  input  wire logic [2:0]  eff_exp,
  input  wire logic [2:0]  lim_exp,
  // mode
  input  wire logic        cache_on,
  input  wire logic        multi_ok,
  // result
  output logic      [9:0]  size_bytes,
  output logic             line_aligned
);
  import pcb_pkg::*;

  // largest block size, from the step size up to the line size, the address sits on
  function automatic logic [2:0] align_exp(input logic [8:0] a, input logic [2:0] eff, input logic [2:0] stp);
    logic [2:0] r;
    r = stp;
    for (int e = 1; e < 8; e++) begin
      if (3'(e) > stp && 3'(e) <= eff && pcb_aligned_to(a, 3'(e))) begin
        r = 3'(e);
      end
    end
    return r;
  endfunction

  logic [7:0] rem_dw_cap;
  logic [2:0] off4;
  logic       partial;
  logic [9:0] part_bytes;
  logic [2:0] step_exp;
  logic       step_ok;
  logic [2:0] algn_exp;
  logic [7:0] lines_fit;
  logic [7:0] max_lines;
  logic [7:0] multi_lines;
  logic [7:0] want_dw;
  logic [7:0] final_dw;

  // a burst never exceeds 128 dwords, so the remaining count is clipped there
  assign rem_dw_cap = (rem_bytes[23:2] > PCB_MAX_DW_WIDE) ? PCB_MAX_DWORDS : rem_bytes[9:2];
  assign off4       = PCB_DWORD_BYTES - {1'b0, addr_low[1:0]};
  assign partial    = (addr_low[1:0] != 2'h0) || (rem_bytes < {21'h000000, PCB_DWORD_BYTES});
  assign part_bytes = (rem_bytes < {21'h000000, off4}) ? {7'h00, rem_bytes[2:0]} : {7'h00, off4};

  // a two-dword line is smaller than the four-dword stepping threshold
  assign step_exp     = (eff_exp < PCB_EXP_STEP) ? eff_exp : PCB_EXP_STEP;
  assign step_ok      = pcb_aligned_to(addr_low, step_exp); // RULE_20
  assign line_aligned = pcb_aligned_to(addr_low, eff_exp); // RULE_20
  assign algn_exp     = align_exp(addr_low, eff_exp, step_exp); // RULE_04

  // whole lines that fit, capped by the burst limit
  assign lines_fit   = rem_dw_cap >> eff_exp; // RULE_13
  assign max_lines   = 8'h01 << (lim_exp - eff_exp); // RULE_13
  assign multi_lines = (lines_fit > max_lines) ? max_lines : lines_fit; // RULE_14

  // choice of burst length in dwords
  always_comb begin
    if (!cache_on) begin
      want_dw = 8'h01 << lim_exp; // RULE_06
    end else if (!step_ok) begin
      want_dw = 8'h01; // RULE_03
    end else if (line_aligned && multi_ok && lines_fit != 8'h00) begin
      want_dw = multi_lines << eff_exp; // RULE_13
    end else begin
      want_dw = 8'h01 << algn_exp; // RULE_04 RULE_05
    end
  end

  // running out of data shortens the burst rather than overrunning the count
  assign final_dw   = (want_dw > rem_dw_cap) ? rem_dw_cap : want_dw;
  assign size_bytes = partial ? part_bytes : {final_dw, 2'b00};

endmodule

// [rtl/pcb_burst_ctl.sv]
// cache line aware burst sizing and command choice for the bus master dma path
`timescale 1ns/1ps

// Functional notes
// RULE_01 - round line size down to power of two
// RULE_02 - effective line is min of line, limit
// RULE_03 - single dwords until four-dword boundary
// RULE_04 - step up to largest aligned burst size
// RULE_05 - after line boundary burst the line size
// RULE_06 - mismatched memory move offsets use legacy mode
// RULE_07 - read line, multiple, invalidate enabled separately
// RULE_08 - eight-bit line size register at 0Ch
// RULE_09 - invalidate needs three enable bits set
// RULE_10 - line size legal and within burst limit
// RULE_11 - fifo must hold one full line
// RULE_12 - invalidate when all hold, else write
// RULE_13 - multi-line burst: largest multiple within limit
// RULE_14 - recompute multiple after every burst
// RULE_15 - software sets limit equal line for single
// RULE_16 - latency timeout finishes to line boundary
// RULE_17 - multi-line burst stops at next line
// RULE_18 - retry releases bus, reissues invalidate
// RULE_19 - disconnect reissues invalidate only if aligned
// RULE_20 - alignment judged on low dword address bits
module pcb_burst_ctl #(
  parameter int FIFO_LVL_W = 10
) (
  // clock and reset
  input  wire logic                   clock,
  input  wire logic                   reset,
  // configuration space access
  input  wire logic                   cfg_wr,
  input  wire logic                   cfg_rd,
  input  wire logic [7:0]             cfg_addr,
  input  wire logic [7:0]             cfg_wdata,
  output logic      [7:0]             cfg_rdata,
  // control bits from the command and operating registers
  input  wire logic                   pci_cmd_mwi_en,
  input  wire logic                   line_size_enable,
  input  wire logic                   write_invalidate_enable,
  input  wire logic                   read_line_enable,
  input  wire logic                   read_multiple_enable,
  input  wire logic [1:0]             dma_mode_burst,
  input  wire logic                   burst_ext,
  // transfer request
  input  wire logic                   xfer_start,
  input  wire logic                   xfer_write,
  input  wire logic                   xfer_mem_move,
  input  wire logic [31:0]            xfer_addr,
  input  wire logic [31:0]            xfer_peer_addr,
  input  wire logic [23:0]            xfer_count,
  input  wire logic [FIFO_LVL_W-1:0]  fifo_bytes,
  // burst issue to the bus engine
  output logic                        burst_req,
  output logic      [31:0]            burst_addr,
  output logic      [9:0]             burst_bytes,
  output logic      [3:0]             burst_cmd,
  input  wire logic                   burst_ack,
  // data phase feedback
  input  wire logic                   data_ack,
  input  wire logic                   target_stop,
  input  wire logic                   latency_expired,
  output logic                        bus_release,
  // status
  output logic                        xfer_busy,
  output logic                        xfer_done
);
  import pcb_pkg::*;

  pcb_state_t  state_q;
  logic [7:0]  cls_q;
  logic [7:0]  cfg_rdata_q;
  logic [31:0] addr_q;
  logic [23:0] rem_q;
  logic        is_write_q;
  logic        legacy_q;
  logic        retry_mwi_q;
  logic        any_data_q;
  logic [9:0]  bleft_q;
  logic        req_q;
  logic [31:0] burst_addr_q;
  logic [9:0]  burst_bytes_q;
  logic [3:0]  cmd_q;
  logic        release_q;
  logic        busy_q;
  logic        done_q;

  logic [2:0]  cls_exp;
  logic        cls_legal;
  logic [2:0]  lim_exp;
  logic [2:0]  eff_exp;
  logic        cache_on;
  logic [9:0]  line_bytes;
  logic [9:0]  limit_bytes;
  logic        size_fit;
  logic        line_aligned;
  logic [9:0]  calc_bytes;
  logic        mwi_ok;
  logic        mwi_sel;
  logic        rd_ok;
  logic        rmul_ok;
  logic        rline_ok;
  logic        multi_ok;
  logic [3:0]  plan_cmd;
  logic        start_legacy;
  logic [2:0]  off4;
  logic [2:0]  pb;
  logic [31:0] next_addr;
  logic [23:0] rem_after;
  logic [9:0]  bleft_after;
  logic        after_aligned;
  logic [8:0]  nxt_end;
  logic        lat_hit;
  logic        retry_seen;
  logic        end_burst;
  logic [23:0] rem_next;
  logic        is_cls_addr;

  // line size seen as power of two, and the limit set by the mode bits
  assign cls_exp   = pcb_round_exp(cls_q); // RULE_01
  assign cls_legal = (cls_exp != PCB_EXP_NONE) && ((cls_q & (cls_q - 8'h01)) == 8'h00); // RULE_10
  assign lim_exp   = pcb_limit_exp(dma_mode_burst, burst_ext); // RULE_02
  assign eff_exp   = (cls_exp < lim_exp) ? cls_exp : lim_exp; // RULE_02
  assign size_fit  = cls_legal && (cls_exp <= lim_exp); // RULE_10

  // a line size below two dwords leaves cache mode off altogether
  assign cache_on    = line_size_enable && (cls_exp != PCB_EXP_NONE) && !legacy_q; // RULE_06
  assign line_bytes  = 10'h004 << eff_exp;
  assign limit_bytes = 10'h004 << lim_exp;

  // command qualification for writes
  assign mwi_ok = cache_on && write_invalidate_enable && pci_cmd_mwi_en // RULE_09
               && size_fit // RULE_10
               && ({{(24 - FIFO_LVL_W){1'b0}}, fifo_bytes} >= {14'h0000, line_bytes}) // RULE_11
               && (rem_q >= {14'h0000, line_bytes})
               && line_aligned && is_write_q; // RULE_12
  // a retried invalidate goes out again unchanged on the next ownership
  assign mwi_sel = is_write_q && (mwi_ok || retry_mwi_q); // RULE_18 RULE_19

  // command qualification for reads; read multiple wins over read line
  assign rd_ok    = cache_on && size_fit && line_aligned && !is_write_q;
  assign rmul_ok  = read_multiple_enable && rd_ok && (rem_q >= {13'h0000, line_bytes, 1'b0}); // RULE_07
  assign rline_ok = read_line_enable && rd_ok && (rem_q >= {14'h0000, limit_bytes}); // RULE_07
  assign multi_ok = is_write_q ? mwi_sel : rmul_ok;

  // command for the next burst
  always_comb begin
    if (is_write_q) begin
      plan_cmd = mwi_sel ? PCB_CMD_WR_INVAL : PCB_CMD_MEM_WRITE; // RULE_12
    end else if (rmul_ok) begin
      plan_cmd = PCB_CMD_READ_MULT;
    end else if (rline_ok) begin
      plan_cmd = PCB_CMD_READ_LINE;
    end else begin
      plan_cmd = PCB_CMD_MEM_READ;
    end
  end

  // burst length for the current position
  pcb_burst_calc u_calc (
    .addr_low     (addr_q[8:0]),
    .rem_bytes    (rem_q),
    .eff_exp      (eff_exp),
    .lim_exp      (lim_exp),
    .cache_on     (cache_on),
    .multi_ok     (multi_ok),
    .size_bytes   (calc_bytes),
    .line_aligned (line_aligned)
  );

  // equal distances to a line boundary keep both sides aligned together
  assign start_legacy = xfer_mem_move
                     && (pcb_line_off(xfer_addr[8:0], eff_exp) != pcb_line_off(xfer_peer_addr[8:0], eff_exp)); // RULE_06

  // bytes moved by the data phase in flight; only the first may be partial
  assign off4          = PCB_DWORD_BYTES - {1'b0, addr_q[1:0]};
  assign pb            = (bleft_q < {7'h00, off4}) ? bleft_q[2:0] : off4;
  assign next_addr     = addr_q + {29'h00000000, pb};
  assign rem_after     = rem_q - {21'h000000, pb};
  assign bleft_after   = bleft_q - {7'h00, pb};
  assign after_aligned = pcb_aligned_to(next_addr[8:0], eff_exp); // RULE_20
  // with a phase completing now, the next one to finish is the following full dword;
  // a target answering every cycle must still see the timeout take effect
  assign nxt_end       = next_addr[8:0] + 9'h004;
  assign lat_hit       = data_ack ? pcb_aligned_to(nxt_end, eff_exp) : after_aligned; // RULE_17

  // burst end: stop from the target, last phase of the burst, or a released ownership
  assign retry_seen = target_stop && !data_ack && !any_data_q; // RULE_18
  assign end_burst  = target_stop || (data_ack && (bleft_after == 10'h000 || release_q));
  assign rem_next   = data_ack ? rem_after : rem_q;

  // configuration register
  assign is_cls_addr = (cfg_addr == PCB_CLS_OFFSET);

  // line size register write and read; other offsets read as zero here
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cls_q       <= PCB_CLS_RESET;
      cfg_rdata_q <= 8'h00;
    end else begin
      if (cfg_wr && is_cls_addr) begin
        cls_q <= cfg_wdata; // RULE_08
      end
      if (cfg_rd) begin
        cfg_rdata_q <= is_cls_addr ? cls_q : 8'h00; // RULE_08
      end
    end
  end

  // transfer sequencer
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_q       <= PCB_IDLE;
      addr_q        <= 32'h00000000;
      rem_q         <= 24'h000000;
      is_write_q    <= 1'b0;
      legacy_q      <= 1'b0;
      retry_mwi_q   <= 1'b0;
      any_data_q    <= 1'b0;
      bleft_q       <= 10'h000;
      req_q         <= 1'b0;
      burst_addr_q  <= 32'h00000000;
      burst_bytes_q <= 10'h000;
      cmd_q         <= PCB_CMD_MEM_READ;
      release_q     <= 1'b0;
      busy_q        <= 1'b0;
      done_q        <= 1'b0;
    end else begin
      done_q <= 1'b0;
      unique case (state_q)
        PCB_IDLE: begin
          if (xfer_start) begin
            addr_q      <= xfer_addr;
            rem_q       <= xfer_count;
            is_write_q  <= xfer_write;
            legacy_q    <= start_legacy; // RULE_06
            retry_mwi_q <= 1'b0;
            if (xfer_count == 24'h000000) begin
              done_q <= 1'b1;
            end else begin
              busy_q  <= 1'b1;
              state_q <= PCB_PLAN;
            end
          end
        end
        PCB_PLAN: begin
          // sizes are taken afresh before every burst
          burst_addr_q  <= addr_q;
          burst_bytes_q <= calc_bytes; // RULE_14
          bleft_q       <= calc_bytes;
          cmd_q         <= plan_cmd;
          req_q         <= 1'b1;
          any_data_q    <= 1'b0;
          retry_mwi_q   <= 1'b0;
          state_q       <= PCB_ISSUE;
        end
        PCB_ISSUE: begin
          if (burst_ack) begin
            req_q   <= 1'b0;
            state_q <= PCB_DATA;
          end
        end
        PCB_DATA: begin
          if (data_ack) begin
            addr_q     <= next_addr;
            rem_q      <= rem_after;
            bleft_q    <= bleft_after;
            any_data_q <= 1'b1;
          end
          if (end_burst) begin
            // retry and disconnect both give up the bus and come straight back
            release_q   <= 1'b0;
            retry_mwi_q <= retry_seen && (cmd_q == PCB_CMD_WR_INVAL); // RULE_18
            if (rem_next == 24'h000000) begin
              busy_q  <= 1'b0;
              done_q  <= 1'b1;
              state_q <= PCB_IDLE;
            end else begin
              state_q <= PCB_PLAN; // RULE_19
            end
          end else if (latency_expired && !release_q) begin
            // an invalidate burst may not stop short of a line end
            release_q <= (cmd_q != PCB_CMD_WR_INVAL) || lat_hit; // RULE_16 RULE_17
          end
        end
      endcase
    end
  end

  // outputs straight from their flip-flops
  assign cfg_rdata   = cfg_rdata_q;
  assign burst_req   = req_q;
  assign burst_addr  = burst_addr_q;
  assign burst_bytes = burst_bytes_q;
  assign burst_cmd   = cmd_q;
  assign bus_release = release_q;
  assign xfer_busy   = busy_q;
  assign xfer_done   = done_q;

endmodule

// [rtl/pcb_pkg.sv]
// constants, types and shared decode functions for the cache line burst controller
package pcb_pkg;

  // configuration space location and reset value of the line size register
  localparam logic [7:0] PCB_CLS_OFFSET = 8'h0C;
  localparam logic [7:0] PCB_CLS_RESET  = 8'h00;

  // bus command codes driven on the command lines during the address phase
  localparam logic [3:0] PCB_CMD_MEM_READ  = 4'h6;
  localparam logic [3:0] PCB_CMD_MEM_WRITE = 4'h7;
  localparam logic [3:0] PCB_CMD_READ_MULT = 4'hC;
  localparam logic [3:0] PCB_CMD_READ_LINE = 4'hE;
  localparam logic [3:0] PCB_CMD_WR_INVAL  = 4'hF;

  // sizes are held as log2 of the size in dwords
  localparam logic [2:0] PCB_EXP_NONE = 3'h0;
  localparam logic [2:0] PCB_EXP_STEP = 3'h2;
  localparam logic [2:0] PCB_EXP_MAX  = 3'h7;

  // byte and dword figures used by the sizing logic
  localparam logic [2:0]  PCB_DWORD_BYTES = 3'h4;
  localparam logic [7:0]  PCB_MAX_DWORDS  = 8'h80;
  localparam logic [21:0] PCB_MAX_DW_WIDE = 22'h000080;

  // controller states
  typedef enum logic [1:0] {
    PCB_IDLE,
    PCB_PLAN,
    PCB_ISSUE,
    PCB_DATA
  } pcb_state_t;

  // byte offset of an address inside a block of 2**e dwords
  function automatic logic [8:0] pcb_line_off(input logic [8:0] a, input logic [2:0] e);
    logic [9:0] mask;
    mask = (10'h004 << e) - 10'h001;
    return a & mask[8:0];
  endfunction

  // true when the address sits on a 2**e dword boundary
  function automatic logic pcb_aligned_to(input logic [8:0] a, input logic [2:0] e);
    return pcb_line_off(a, e) == 9'h000;
  endfunction

  // line size register rounded down to a power of two of 2..128 dwords, 0 if below 2
  function automatic logic [2:0] pcb_round_exp(input logic [7:0] v);
    logic [2:0] r;
    r = PCB_EXP_NONE;
    for (int i = 1; i < 8; i++) begin
      if (v[i]) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction

  // burst limit from the two mode burst bits and the burst extension bit
  function automatic logic [2:0] pcb_limit_exp(input logic [1:0] mode, input logic ext);
    logic [2:0] r;
    if (!ext) begin
      r = {1'b0, mode} + 3'h1;
    end else if (mode[1]) begin
      r = PCB_EXP_MAX;
    end else begin
      r = {2'b10, mode[0]} + 3'h1;
    end
    return r;
  endfunction

endpackage
